// [core/aqc_cfg.svh]
`ifndef AQC_CFG_SVH
`define AQC_CFG_SVH
`define AQC_DATA_W 16
`define AQC_FIFO_DEPTH 16
`define AQC_MEM_DEPTH 256
`define AQC_ADDR_W 8
`define AQC_PROG_W 16
// key codes presented on key_code with key_valid
`define AQC_KEY_W 4
`define AQC_KEY_IMMEDIATE 4'h1
`define AQC_KEY_DISPLAY 4'h2
`define AQC_KEY_PROGRAM 4'h3
`define AQC_KEY_STORE_MEM 4'h4
`define AQC_KEY_ACQUISITION_MEMORY 4'h5
`define AQC_KEY_START_STOP 4'h6
`define AQC_KEY_EXECUTE 4'h7
`define AQC_KEY_QUALIFY 4'h8
// status codes
`define AQC_ST_NONE 2'h0
`define AQC_ST_PROG_ERR 2'h1
`define AQC_ST_STORE_EMPTY 2'h2
`endif

// [core/aqc_pkg.sv]
package aqc_pkg;
	typedef enum logic [2:0] {
		MODE_PROG = 3'b000,
		MODE_DISP = 3'b001,
		MODE_IMM = 3'b010,
		MODE_RUN = 3'b011
	} aqc_mode_type;
	typedef enum logic [1:0] {
		IMM_IDLE = 2'b00,
		IMM_DEST = 2'b01,
		IMM_PEND = 2'b10
	} aqc_imm_type;
	typedef enum logic [1:0] {
		PEND_NONE = 2'b00,
		PEND_TO_STORE = 2'b01,
		PEND_FROM_STORE = 2'b10,
		PEND_OTHER = 2'b11
	} aqc_pend_type;
	typedef enum logic [1:0] {
		QK_STRUCT = 2'b00,
		QK_CMD = 2'b01,
		QK_ERR = 2'b10
	} aqc_qkey_type;
endpackage

// [core/aqc_fifo.sv]
module aqc_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0] cnt_r;
	logic wr;
	logic rd;
	assign in_ready = (cnt_r != DEPTH[AW:0]);
	assign out_valid = (cnt_r != '0);
	assign out_data = mem[rp_r];
	assign wr = in_valid && in_ready;
	assign rd = out_valid && out_ready;
	always_ff @(posedge ref_clk) begin
		if (wr) begin
			mem[wp_r] <= in_data;
		end
	end
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			if (wr) begin
				wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
			end
			if (rd) begin
				rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
			end
			cnt_r <= cnt_r + (AW+1)'(wr) - (AW+1)'(rd);
		end
	end
endmodule

// [core/aqc_ctrl.sv]
`include "aqc_cfg.svh"
// How it works
// - without any qualification in the program, every sampled word is stored unless the buffer is full
// - the qualify block event is evaluated every cycle, whatever test is active
// - with qualification present, store only on block event or store command
// - a store command stores that cycle's word regardless of block event
// - block is qualify, event or compound with complements, end; arrives evaluated
// - only one qualify block per program; store commands unlimited
// - qualify key is structure in empty program or after end-test, else command
// - unstored trigger marks last stored word, or first word when none stored
// - run-toggle outside run with a clean program enters run at test one
// - run-toggle in run stops acquisition, ends program, enters display mode
// - a missing final end marker is appended at start if nothing else wrong
// - conflicting or incomplete program posts an error and stays out of run
// - only the working program store runs; storage must be transferred first
// - copy to storage swaps any stored program back, then returns to prior mode
// - copy from empty storage posts error; always return to prior mode
// - display-program sequence shows working program and enters programming mode
// - display-storage runs on its last key, enters display, keeps immediate area
// - other transfers wait for the execute field, then return to prior mode
module aqc_ctrl #(
	parameter int DATA_W = `AQC_DATA_W,
	parameter int FIFO_DEPTH = `AQC_FIFO_DEPTH,
	parameter int PROG_W = `AQC_PROG_W
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic state_clk_en,
	input wire logic [DATA_W-1:0] sut_data,
	input wire logic qual_block_event,
	input wire logic store_cmd_exec,
	input wire logic trigger_exec,
	input wire logic key_valid,
	input wire logic [`AQC_KEY_W-1:0] key_code,
	input wire logic qual_key_ctx_struct,
	input wire logic qual_key_ctx_cmd,
	input wire logic prog_uses_qualify,
	input wire logic prog_has_block,
	input wire logic prog_conflict,
	input wire logic prog_incomplete,
	input wire logic prog_end_missing,
	input wire logic [PROG_W-1:0] work_prog_in,
	output logic [DATA_W-1:0] mem_wdata,
	output logic mem_wvalid,
	input wire logic mem_wready,
	output logic [`AQC_ADDR_W-1:0] mem_waddr,
	output logic [`AQC_ADDR_W-1:0] trig_mark_addr,
	output logic trig_mark_valid,
	output logic [2:0] mode,
	output logic run_start,
	output logic append_end,
	output logic [1:0] status_code,
	output logic imm_area_keep,
	output logic show_prog,
	output logic [PROG_W-1:0] work_prog_load,
	output logic work_prog_load_en,
	output logic [1:0] qkey_kind,
	output logic block_dup_err
);
	aqc_pkg::aqc_mode_type mode_r;
	aqc_pkg::aqc_mode_type prior_r;
	aqc_pkg::aqc_imm_type imm_r;
	aqc_pkg::aqc_pend_type pend_r;
	logic [`AQC_KEY_W-1:0] dest_r;
	logic [PROG_W-1:0] store_prog_r;
	logic store_full_r;
	logic store_en;
	logic fifo_ready;
	logic fifo_valid;
	logic [DATA_W-1:0] fifo_data;
	logic [`AQC_ADDR_W-1:0] waddr_r;
	logic stored_any_r;
	logic [`AQC_ADDR_W-1:0] last_addr_r;
	logic trig_done_r;
	logic prog_bad;
	logic run_key;
	logic [DATA_W-1:0] mem_wdata_r;
	logic mem_wvalid_r;
	logic run_start_r;
	logic append_end_r;
	logic [1:0] status_r;
	logic keep_r;
	logic show_prog_r;
	logic [PROG_W-1:0] load_r;
	logic load_en_r;
	logic [1:0] qkey_r;
	logic dup_r;

	// combinational so the decision belongs to the word sampled this cycle
	always_comb begin
		store_en = 1'b0;
		if (mode_r == aqc_pkg::MODE_RUN && state_clk_en) begin
			if (!prog_uses_qualify) begin
				store_en = 1'b1;
			end else begin
				// block event is a free-running input, never gated by active test
				store_en = (prog_has_block && qual_block_event) || store_cmd_exec;
			end
		end
	end

	// words are dropped when the memory side stalls long enough to fill the buffer
	aqc_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.in_valid(store_en),
		.in_ready(fifo_ready),
		.in_data(sut_data),
		.out_valid(fifo_valid),
		.out_ready(mem_wready || !mem_wvalid_r),
		.out_data(fifo_data)
	);

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			mem_wvalid_r <= 1'b0;
			mem_wdata_r <= '0;
			waddr_r <= '0;
		end else begin
			if (mem_wready || !mem_wvalid_r) begin
				mem_wvalid_r <= fifo_valid;
				mem_wdata_r <= fifo_data;
				if (mem_wvalid_r) begin
					waddr_r <= waddr_r + 1'b1;
				end
			end
			// every run fills memory from word zero, so trigger marks match addresses
			if (run_start_r) begin
				waddr_r <= '0;
			end
		end
	end

	// address each stored word will take, tracked at the input side of the buffer
	logic [`AQC_ADDR_W-1:0] in_addr_r;
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			in_addr_r <= '0;
			stored_any_r <= 1'b0;
			last_addr_r <= '0;
			trig_done_r <= 1'b0;
			trig_mark_addr <= '0;
			trig_mark_valid <= 1'b0;
		end else begin
			if (run_start_r) begin
				in_addr_r <= '0;
				stored_any_r <= 1'b0;
				trig_done_r <= 1'b0;
				trig_mark_valid <= 1'b0;
			end else begin
				if (store_en && fifo_ready) begin
					in_addr_r <= in_addr_r + 1'b1;
					last_addr_r <= in_addr_r;
					stored_any_r <= 1'b1;
				end
				if (trigger_exec && state_clk_en && mode_r == aqc_pkg::MODE_RUN && !trig_done_r) begin
					trig_done_r <= 1'b1;
					trig_mark_valid <= 1'b1;
					if (store_en) begin
						trig_mark_addr <= in_addr_r;
					end else if (stored_any_r) begin
						trig_mark_addr <= last_addr_r;
					end else begin
						trig_mark_addr <= '0;
					end
				end
			end
		end
	end

	assign prog_bad = prog_conflict || prog_incomplete;
	assign run_key = key_valid && key_code == `AQC_KEY_START_STOP;

	// mode control and immediate-mode key sequencing
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			mode_r <= aqc_pkg::MODE_PROG;
			prior_r <= aqc_pkg::MODE_PROG;
			imm_r <= aqc_pkg::IMM_IDLE;
			pend_r <= aqc_pkg::PEND_NONE;
			dest_r <= '0;
			store_prog_r <= '0;
			store_full_r <= 1'b0;
			run_start_r <= 1'b0;
			append_end_r <= 1'b0;
			status_r <= `AQC_ST_NONE;
			keep_r <= 1'b0;
			show_prog_r <= 1'b0;
			load_r <= '0;
			load_en_r <= 1'b0;
		end else begin
			run_start_r <= 1'b0;
			append_end_r <= 1'b0;
			show_prog_r <= 1'b0;
			load_en_r <= 1'b0;
			if (run_key) begin
				if (mode_r == aqc_pkg::MODE_RUN) begin
					mode_r <= aqc_pkg::MODE_DISP;
				end else if (prog_bad) begin
					status_r <= `AQC_ST_PROG_ERR;
				end else begin
					// only the working store is ever executed
					mode_r <= aqc_pkg::MODE_RUN;
					run_start_r <= 1'b1;
					append_end_r <= prog_end_missing;
					status_r <= `AQC_ST_NONE;
					imm_r <= aqc_pkg::IMM_IDLE;
					keep_r <= 1'b0;
				end
			end else if (key_valid && key_code == `AQC_KEY_IMMEDIATE
				&& (mode_r == aqc_pkg::MODE_PROG || mode_r == aqc_pkg::MODE_DISP
				|| mode_r == aqc_pkg::MODE_IMM)) begin
				// a fresh immediate press discards any command in progress
				if (mode_r != aqc_pkg::MODE_IMM) begin
					prior_r <= mode_r;
				end
				mode_r <= aqc_pkg::MODE_IMM;
				imm_r <= aqc_pkg::IMM_DEST;
				pend_r <= aqc_pkg::PEND_NONE;
				keep_r <= 1'b0;
			end else if (key_valid && mode_r == aqc_pkg::MODE_IMM) begin
				case (imm_r)
					aqc_pkg::IMM_DEST: begin
						dest_r <= key_code;
						imm_r <= aqc_pkg::IMM_PEND;
						pend_r <= aqc_pkg::PEND_NONE;
					end
					aqc_pkg::IMM_PEND: begin
						if (pend_r == aqc_pkg::PEND_NONE) begin
							if (dest_r == `AQC_KEY_DISPLAY && key_code == `AQC_KEY_PROGRAM) begin
								show_prog_r <= 1'b1;
								mode_r <= aqc_pkg::MODE_PROG;
								imm_r <= aqc_pkg::IMM_IDLE;
							end else if (dest_r == `AQC_KEY_DISPLAY
								&& key_code == `AQC_KEY_STORE_MEM) begin
								mode_r <= aqc_pkg::MODE_DISP;
								keep_r <= 1'b1;
								imm_r <= aqc_pkg::IMM_IDLE;
							end else if (dest_r == `AQC_KEY_DISPLAY) begin
								mode_r <= aqc_pkg::MODE_DISP;
								imm_r <= aqc_pkg::IMM_IDLE;
							end else if (dest_r == `AQC_KEY_STORE_MEM
								&& key_code == `AQC_KEY_PROGRAM) begin
								pend_r <= aqc_pkg::PEND_TO_STORE;
							end else if (dest_r == `AQC_KEY_PROGRAM
								&& key_code == `AQC_KEY_STORE_MEM) begin
								pend_r <= aqc_pkg::PEND_FROM_STORE;
							end else begin
								pend_r <= aqc_pkg::PEND_OTHER;
							end
						end else if (key_code == `AQC_KEY_EXECUTE) begin
							case (pend_r)
								aqc_pkg::PEND_TO_STORE: begin
									store_prog_r <= work_prog_in;
									store_full_r <= 1'b1;
									if (store_full_r) begin
										load_r <= store_prog_r;
										load_en_r <= 1'b1;
									end
								end
								aqc_pkg::PEND_FROM_STORE: begin
									if (store_full_r) begin
										load_r <= store_prog_r;
										load_en_r <= 1'b1;
									end else begin
										status_r <= `AQC_ST_STORE_EMPTY;
									end
								end
								default: begin
								end
							endcase
							mode_r <= prior_r;
							imm_r <= aqc_pkg::IMM_IDLE;
							pend_r <= aqc_pkg::PEND_NONE;
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// qualify key classification and block count check
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			qkey_r <= aqc_pkg::QK_ERR;
			dup_r <= 1'b0;
		end else if (key_valid && key_code == `AQC_KEY_QUALIFY
			&& mode_r == aqc_pkg::MODE_PROG) begin
			if (qual_key_ctx_struct) begin
				qkey_r <= aqc_pkg::QK_STRUCT;
				dup_r <= prog_has_block;
			end else if (qual_key_ctx_cmd) begin
				qkey_r <= aqc_pkg::QK_CMD;
				dup_r <= 1'b0;
			end else begin
				qkey_r <= aqc_pkg::QK_ERR;
				dup_r <= 1'b0;
			end
		end
	end

	assign mem_wdata = mem_wdata_r;
	assign mem_wvalid = mem_wvalid_r;
	assign mem_waddr = waddr_r;
	assign mode = mode_r;
	assign run_start = run_start_r;
	assign append_end = append_end_r;
	assign status_code = status_r;
	assign imm_area_keep = keep_r;
	assign show_prog = show_prog_r;
	assign work_prog_load = load_r;
	assign work_prog_load_en = load_en_r;
	assign qkey_kind = qkey_r;
	assign block_dup_err = dup_r;

	property p_run_entry;
		@(posedge ref_clk) disable iff (!rstn)
		(run_key && mode_r != aqc_pkg::MODE_RUN && !prog_bad) |=> mode_r == aqc_pkg::MODE_RUN && run_start_r;
	endproperty
	a_run_entry: assert property (p_run_entry) else $error("run not entered");
	property p_run_stop;
		@(posedge ref_clk) disable iff (!rstn)
		(run_key && mode_r == aqc_pkg::MODE_RUN) |=> mode_r == aqc_pkg::MODE_DISP;
	endproperty
	a_run_stop: assert property (p_run_stop) else $error("run not stopped");
	property p_bad_prog;
		@(posedge ref_clk) disable iff (!rstn)
		(run_key && mode_r != aqc_pkg::MODE_RUN && prog_bad) |=> mode_r != aqc_pkg::MODE_RUN && status_r == `AQC_ST_PROG_ERR;
	endproperty
	a_bad_prog: assert property (p_bad_prog) else $error("bad program ran");
	property p_append;
		@(posedge ref_clk) disable iff (!rstn)
		(run_key && mode_r != aqc_pkg::MODE_RUN && !prog_bad && prog_end_missing) |=> append_end_r;
	endproperty
	a_append: assert property (p_append) else $error("end not appended");
	property p_store_all;
		@(posedge ref_clk) disable iff (!rstn)
		(mode_r == aqc_pkg::MODE_RUN && state_clk_en && !prog_uses_qualify) |-> store_en;
	endproperty
	a_store_all: assert property (p_store_all) else $error("unqualified word dropped");
	property p_store_cmd;
		@(posedge ref_clk) disable iff (!rstn)
		(mode_r == aqc_pkg::MODE_RUN && state_clk_en && store_cmd_exec) |-> store_en;
	endproperty
	a_store_cmd: assert property (p_store_cmd) else $error("store command ignored");
	property p_qual_gate;
		@(posedge ref_clk) disable iff (!rstn)
		(prog_uses_qualify && !store_cmd_exec && !(prog_has_block && qual_block_event)) |-> !store_en;
	endproperty
	a_qual_gate: assert property (p_qual_gate) else $error("unqualified store");
	property p_empty_store;
		@(posedge ref_clk) disable iff (!rstn)
		(key_valid && key_code == `AQC_KEY_EXECUTE && mode_r == aqc_pkg::MODE_IMM
			&& imm_r == aqc_pkg::IMM_PEND && pend_r == aqc_pkg::PEND_FROM_STORE && !store_full_r
			&& !run_key) |=> status_r == `AQC_ST_STORE_EMPTY && mode_r == $past(prior_r);
	endproperty
	a_empty_store: assert property (p_empty_store) else $error("empty storage not reported");
endmodule

// [tb/aqc_mem_model.sv]
`include "aqc_cfg.svh"
module aqc_mem_model (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic stall,
	input wire logic mem_wvalid,
	input wire logic [`AQC_DATA_W-1:0] mem_wdata,
	input wire logic [`AQC_ADDR_W-1:0] mem_waddr,
	output logic mem_wready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [`AQC_DATA_W-1:0] words[$];
	logic [`AQC_ADDR_W-1:0] addrs[$];
	// ready follows stall one cycle late, like a slow memory port
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			mem_wready <= 1'b0;
		else
			mem_wready <= !stall;
	end
	// a word counts only at the edge where valid and ready meet
	always @(posedge ref_clk) begin
		if (rstn && mem_wvalid && mem_wready) begin
			words.push_back(mem_wdata);
			addrs.push_back(mem_waddr);
		end
	end
endmodule

// [tb/acq_store_qualify_run_ctrl_test.sv]
`include "aqc_cfg.svh"
module acq_store_qualify_run_ctrl_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic state_clk_en = 1'b0;
	logic [15:0] sut_data = 16'h0000;
	logic qual_block_event = 1'b0;
	logic store_cmd_exec = 1'b0;
	logic trigger_exec = 1'b0;
	logic key_valid = 1'b0;
	logic [3:0] key_code = 4'h0;
	logic qual_key_ctx_struct = 1'b0;
	logic qual_key_ctx_cmd = 1'b0;
	logic prog_uses_qualify = 1'b0;
	logic prog_has_block = 1'b0;
	logic prog_conflict = 1'b0;
	logic prog_incomplete = 1'b0;
	logic prog_end_missing = 1'b0;
	logic [15:0] work_prog_in = 16'h0000;
	logic stall = 1'b0;
	logic [15:0] mem_wdata;
	logic mem_wvalid;
	logic mem_wready;
	logic [7:0] mem_waddr;
	logic [7:0] trig_mark_addr;
	logic trig_mark_valid;
	logic [2:0] mode;
	logic run_start;
	logic append_end;
	logic [1:0] status_code;
	logic imm_area_keep;
	logic show_prog;
	logic [15:0] work_prog_load;
	logic work_prog_load_en;
	logic [1:0] qkey_kind;
	logic block_dup_err;
	int failures = 0;
	int cmp_count = 0;
	int cyc = 0;
	logic [15:0] exp_q[$];
	aqc_ctrl dut (.ref_clk, .rstn, .state_clk_en, .sut_data, .qual_block_event,
		.store_cmd_exec, .trigger_exec, .key_valid, .key_code, .qual_key_ctx_struct,
		.qual_key_ctx_cmd, .prog_uses_qualify, .prog_has_block, .prog_conflict,
		.prog_incomplete, .prog_end_missing, .work_prog_in, .mem_wdata, .mem_wvalid,
		.mem_wready, .mem_waddr, .trig_mark_addr, .trig_mark_valid, .mode, .run_start,
		.append_end, .status_code, .imm_area_keep, .show_prog, .work_prog_load,
		.work_prog_load_en, .qkey_kind, .block_dup_err);
	aqc_mem_model mem (.ref_clk, .rstn, .stall, .mem_wvalid, .mem_wdata, .mem_waddr,
		.mem_wready);
	always #12.5 ref_clk = ~ref_clk;
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// run is about 300 cycles; the ceiling leaves wide margin
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			end_of_test();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// outputs answer at the edge that takes the key; look just after it
	task automatic key(input logic [3:0] k);
		@(posedge ref_clk);
		key_valid <= 1'b1;
		key_code <= k;
		@(posedge ref_clk);
		key_valid <= 1'b0;
		#1;
	endtask
	task automatic feed(input logic [15:0] d, input logic ev, input logic cmd, input logic trg);
		@(posedge ref_clk);
		state_clk_en <= 1'b1;
		sut_data <= d;
		qual_block_event <= ev;
		store_cmd_exec <= cmd;
		trigger_exec <= trg;
	endtask
	task automatic idle();
		@(posedge ref_clk);
		state_clk_en <= 1'b0;
		qual_block_event <= 1'b0;
		store_cmd_exec <= 1'b0;
		trigger_exec <= 1'b0;
	endtask
	task automatic drain(input int n);
		int i;
		i = 0;
		while (mem.words.size() < n && i < 100) begin
			@(posedge ref_clk);
			i++;
		end
		repeat (4) @(posedge ref_clk);
		#1;
	endtask
	task automatic chk_mem(input int n);
		chk(mem.words.size(), exp_q.size());
		for (int k = 0; k < n && k < mem.words.size(); k++) begin
			chk(mem.words[k], exp_q[k]);
			chk(mem.addrs[k], 8'(k));
		end
	endtask
	task automatic start_run();
		mem.words.delete();
		mem.addrs.delete();
		exp_q.delete();
		key(`AQC_KEY_START_STOP);
		chk(mode, aqc_pkg::MODE_RUN);
	endtask
	task automatic t_qkey();
		@(posedge ref_clk);
		qual_key_ctx_struct <= 1'b1;
		key(`AQC_KEY_QUALIFY);
		chk(qkey_kind, aqc_pkg::QK_STRUCT);
		chk(block_dup_err, 1'b0);
		prog_has_block <= 1'b1;
		key(`AQC_KEY_QUALIFY);
		chk(block_dup_err, 1'b1);
		prog_has_block <= 1'b0;
		qual_key_ctx_struct <= 1'b0;
		qual_key_ctx_cmd <= 1'b1;
		key(`AQC_KEY_QUALIFY);
		chk(qkey_kind, aqc_pkg::QK_CMD);
		qual_key_ctx_cmd <= 1'b0;
	endtask
	task automatic t_err();
		for (int i = 0; i < 2; i++) begin
			@(posedge ref_clk);
			prog_conflict <= (i == 0);
			prog_incomplete <= (i == 1);
			key(`AQC_KEY_START_STOP);
			chk(mode, aqc_pkg::MODE_PROG);
			chk(status_code, `AQC_ST_PROG_ERR);
			chk(run_start, 1'b0);
		end
		prog_conflict <= 1'b0;
		prog_incomplete <= 1'b0;
	endtask
	task automatic t_run_all();
		@(posedge ref_clk);
		prog_end_missing <= 1'b1;
		start_run();
		chk(run_start, 1'b1);
		chk(append_end, 1'b1);
		chk(status_code, `AQC_ST_NONE);
		prog_end_missing <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			feed(16'h5A00 + 16'(i), 1'b0, 1'b0, 1'b0);
			exp_q.push_back(16'h5A00 + 16'(i));
		end
		idle();
		drain(6);
		chk_mem(6);
		key(`AQC_KEY_START_STOP);
		chk(mode, aqc_pkg::MODE_DISP);
		feed(16'hDEAD, 1'b0, 1'b1, 1'b0);
		idle();
		drain(7);
		chk(mem.words.size(), 6);
	endtask
	task automatic t_qual();
		@(posedge ref_clk);
		prog_uses_qualify <= 1'b1;
		prog_has_block <= 1'b1;
		// trigger on an unstored cycle: first with nothing stored, then after three words
		for (int r = 0; r < 2; r++) begin
			start_run();
			for (int i = 0; i < 8; i++) begin
				feed(16'hA0 + 16'(i), i[0], i[1], i == 4 * r);
				if (i[0] || i[1])
					exp_q.push_back(16'hA0 + 16'(i));
			end
			idle();
			drain(6);
			chk_mem(6);
			chk(trig_mark_valid, 1'b1);
			chk(trig_mark_addr, r ? 8'h02 : 8'h00);
			key(`AQC_KEY_START_STOP);
		end
		prog_uses_qualify <= 1'b0;
		prog_has_block <= 1'b0;
	endtask
	task automatic t_fifo();
		@(posedge ref_clk);
		stall <= 1'b1;
		start_run();
		for (int i = 0; i < 20; i++) begin
			feed(16'hC000 + 16'(i), 1'b0, 1'b0, i == 3);
			exp_q.push_back(16'hC000 + 16'(i));
		end
		idle();
		stall <= 1'b0;
		drain(16);
		// the output register holds one word beyond the sixteen queued; the rest are lost
		chk(mem.words.size(), `AQC_FIFO_DEPTH + 1);
		for (int k = 0; k < `AQC_FIFO_DEPTH + 1; k++)
			chk(mem.words[k], exp_q[k]);
		chk(trig_mark_addr, 8'h03);
		key(`AQC_KEY_START_STOP);
	endtask
	task automatic seq(input logic [3:0] d, input logic [3:0] s, input logic x);
		key(`AQC_KEY_IMMEDIATE);
		chk(mode, aqc_pkg::MODE_IMM);
		key(d);
		key(s);
		if (x) begin
			chk(mode, aqc_pkg::MODE_IMM);
			key(`AQC_KEY_EXECUTE);
			chk(mode, aqc_pkg::MODE_DISP);
		end
	endtask
	task automatic t_imm();
		seq(`AQC_KEY_PROGRAM, `AQC_KEY_STORE_MEM, 1'b1);
		chk(status_code, `AQC_ST_STORE_EMPTY);
		chk(work_prog_load_en, 1'b0);
		work_prog_in <= 16'h1234;
		seq(`AQC_KEY_STORE_MEM, `AQC_KEY_PROGRAM, 1'b1);
		chk(work_prog_load_en, 1'b0);
		work_prog_in <= 16'h5678;
		seq(`AQC_KEY_STORE_MEM, `AQC_KEY_PROGRAM, 1'b1);
		chk(work_prog_load_en, 1'b1);
		chk(work_prog_load, 16'h1234);
		seq(`AQC_KEY_PROGRAM, `AQC_KEY_STORE_MEM, 1'b1);
		chk(work_prog_load_en, 1'b1);
		chk(work_prog_load, 16'h5678);
		seq(`AQC_KEY_DISPLAY, `AQC_KEY_PROGRAM, 1'b0);
		chk(show_prog, 1'b1);
		chk(mode, aqc_pkg::MODE_PROG);
		seq(`AQC_KEY_DISPLAY, `AQC_KEY_STORE_MEM, 1'b0);
		chk(mode, aqc_pkg::MODE_DISP);
		chk(imm_area_keep, 1'b1);
		seq(`AQC_KEY_ACQUISITION_MEMORY, `AQC_KEY_ACQUISITION_MEMORY, 1'b1);
		chk(imm_area_keep, 1'b0);
	endtask
	initial begin
		repeat (12) @(posedge ref_clk);
		rstn <= 1'b1;
		#1;
		chk(mode, aqc_pkg::MODE_PROG);
		t_qkey();
		t_err();
		t_run_all();
		t_qual();
		t_fifo();
		t_imm();
		end_of_test();
	end
endmodule
